/* inc/fcc_defs.svh */
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH

// Register indices; the byte address is four times the index
`define FCC_IDX_CLKDIV 5'h00
`define FCC_IDX_SEC 5'h01
`define FCC_IDX_CNFG 5'h03
`define FCC_IDX_PROT 5'h04
`define FCC_IDX_STAT 5'h05
`define FCC_IDX_CMD 5'h06
`define FCC_IDX_TADDRH 5'h08
`define FCC_IDX_TADDRL 5'h09
`define FCC_IDX_TDATAH 5'h0a
`define FCC_IDX_TDATAL 5'h0b
`define FCC_IDX_EVT 5'h10
`define FCC_IDX_MASK 5'h11

// Bus address layout (byte address)
`define FCC_ADDR_W 16
`define FCC_ARRAY_SEL 15
`define FCC_WADDR_W 13

// Clock divider register fields
`define FCC_DIV_LOADED 7
`define FCC_DIV_PRE8 6

// Configuration register fields
`define FCC_CNF_BUFFER_EMPTY_IRQ_ENABLE 7
`define FCC_CNF_COMPLETE_IRQ_ENABLE 6
`define FCC_CNF_BACKDOOR_KEY_ACCESS 5

// Protection register fields
`define FCC_PR_OPEN 7
`define FCC_PR_HDIS 5
`define FCC_PR_LDIS 2

// Status register fields
`define FCC_ST_COMMAND_BUFFER_EMPTY_FLAG 7
`define FCC_ST_COMMAND_COMPLETE_FLAG 6
`define FCC_ST_PROTECTION_VIOLATION_FLAG 5
`define FCC_ST_ACCESS_ERROR_FLAG 4

// Event register bits
`define FCC_EV_EMPTY 0
`define FCC_EV_DONE 1
`define FCC_EV_PROTECTION_VIOLATION_FLAG 2
`define FCC_EV_ACCESS_ERROR_FLAG 3

// Command codes and masks
`define FCC_CMD_PROGRAM 8'h20
`define FCC_CMD_MASK 8'h65

// Reset values and array geometry
`define FCC_PROT_RST 8'hff
`define FCC_SEC_RST 8'h02
`define FCC_ARRAY_WORDS 14'h2000
`define FCC_HIGH_UNIT 14'h0400
`define FCC_LOW_UNIT 14'h0100

// Program algorithm length in divided flash clock periods
`define FCC_PGM_TICKS 8'h28

`endif

/* inc/fcc_pkg.sv */
package fcc_pkg;
   typedef logic [15:0] fcc_word_t;
   typedef logic [12:0] fcc_waddr_t;
   typedef enum logic [1:0] {SEQ_EMPTY, SEQ_ADDR, SEQ_CMD} fcc_seq_t;
endpackage

/* inc/fcc_div_if.sv */
`timescale 1ns/100ps
// Divider settings out, flash clock enable back
interface fcc_div_if;
   logic prescale_by_eight;
   logic [5:0] divider_field;
   logic tick;
   modport ctrl (output prescale_by_eight, output divider_field, input tick);
   modport gen (input prescale_by_eight, input divider_field, output tick);
endinterface

/* hw/fcc_clk_div.sv */
`timescale 1ns/100ps
// Divided flash clock as a one-cycle enable
module fcc_clk_div (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Divider settings and enable
   fcc_div_if.gen div
);
   logic [2:0] pre_ff;
   logic [5:0] cnt_ff;
   logic tick_ff;
   logic pre_en;

   // Optional divide by eight ahead of the main divider
   assign pre_en = !div.prescale_by_eight || (pre_ff == 3'h7);

   // Free running prescale counter
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pre_ff <= 3'h0;
      end else begin
         pre_ff <= pre_ff + 3'h1;
      end
   end

   // Divide by field plus one; >= copes with a field shrunk mid-count
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 6'h00;
         tick_ff <= 1'b0;
      end else if (pre_en) begin
         if (cnt_ff >= div.divider_field) begin
            cnt_ff <= 6'h00;
            tick_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + 6'h01;
            tick_ff <= 1'b0;
         end
      end else begin
         tick_ff <= 1'b0;
      end
   end

   assign div.tick = tick_ff;
endmodule

/* hw/fcc_ctrl.sv */
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`include "fcc_defs.svh"
module fcc_ctrl (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Avalon-MM slave
   input wire logic [15:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Interrupt
   output logic IRQ_O,
   // Array program port
   output logic PGM_ACTIVE_O,
   output logic PGM_STROBE_O,
   output fcc_pkg::fcc_waddr_t PGM_ADDR_O,
   output fcc_pkg::fcc_word_t PGM_DATA_O
);
   import fcc_pkg::*;

   fcc_div_if div_if ();

   logic ack_ff;
   logic [7:0] rdata_ff;
   logic div_ld_ff;
   logic pre8_ff;
   logic [5:0] divider_field_ff;
   logic buffer_empty_irq_enable_ff;
   logic complete_irq_enable_ff;
   logic backdoor_key_access_ff;
   logic [7:0] prot_ff;
   logic [7:0] cmd_ff;
   fcc_seq_t seq_ff;
   logic command_buffer_empty_flag_ff;
   logic protection_violation_flag_ff;
   logic access_error_flag_ff;
   fcc_waddr_t buf_addr_ff;
   fcc_word_t buf_data_ff;
   logic busy_ff;
   logic [7:0] ticks_ff;
   logic strobe_ff;
   fcc_waddr_t pgm_addr_ff;
   fcc_word_t pgm_data_ff;
   logic [3:0] evt_ff;
   logic [3:0] mask_ff;
   logic command_buffer_empty_flag_d_ff;
   logic command_complete_flag_d_ff;

   logic wr_go;
   logic reg_hit;
   logic [4:0] reg_idx;
   logic [7:0] wd;
   logic arr_wr;
   logic arr_ok;
   logic cmd_wr;
   logic launch_req;
   logic acc_set;
   logic pv_set;
   logic launch;
   logic take;
   logic command_complete_flag;
   logic [3:0] evt_set;
   logic [7:0] rd_mux;

   // Is the requested word inside a protected region
   function automatic logic is_protected(input fcc_waddr_t a, input logic [7:0] p);
      logic [13:0] wa;
      logic [13:0] hi_base;
      logic [13:0] lo_top;
      wa = {1'b0, a};
      hi_base = `FCC_ARRAY_WORDS - (`FCC_HIGH_UNIT << p[4:3]);
      lo_top = `FCC_LOW_UNIT << p[1:0];
      if (!p[`FCC_PR_OPEN]) begin
         is_protected = 1'b1;
      end else begin
         is_protected = (!p[`FCC_PR_HDIS] && (wa >= hi_base)) ||
                        (!p[`FCC_PR_LDIS] && (wa < lo_top));
      end
   endfunction

   // Write strobe for one register index
   function automatic logic reg_wr(input logic go, input logic hit,
                                   input logic [4:0] idx, input logic [4:0] want);
      reg_wr = go && hit && (idx == want);
   endfunction

   fcc_clk_div u_div (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .div(div_if.gen)
   );

   assign div_if.prescale_by_eight = pre8_ff;
   assign div_if.divider_field = divider_field_ff;

   // Bus decode; every access answers at the second edge
   assign reg_idx = AVS_ADDRESS_I[6:2];
   assign reg_hit = !AVS_ADDRESS_I[`FCC_ARRAY_SEL] && (AVS_ADDRESS_I[14:7] == 8'h00) &&
                    (AVS_ADDRESS_I[1:0] == 2'h0);
   assign wr_go = AVS_WRITE_I && ack_ff && AVS_BYTEENABLE_I[0];
   assign wd = AVS_WRITEDATA_I[7:0];
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_ff;
   assign AVS_READDATA_O = {24'h000000, rdata_ff};

   // Single wait state toggle
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (AVS_READ_I || AVS_WRITE_I) && !ack_ff;
      end
   end

   // Complete means buffer empty and nothing running
   assign command_complete_flag = command_buffer_empty_flag_ff && !busy_ff;

   // Read mux; unmapped and reserved indices read zero
   always_comb begin
      rd_mux = 8'h00;
      if (reg_hit) begin
         case (reg_idx)
            `FCC_IDX_CLKDIV: rd_mux = {div_ld_ff, pre8_ff, divider_field_ff};
            `FCC_IDX_SEC: rd_mux = `FCC_SEC_RST;
            `FCC_IDX_CNFG: rd_mux = {buffer_empty_irq_enable_ff, complete_irq_enable_ff, backdoor_key_access_ff, 5'h00};
            `FCC_IDX_PROT: rd_mux = prot_ff;
            `FCC_IDX_STAT: rd_mux = {command_buffer_empty_flag_ff, command_complete_flag, protection_violation_flag_ff, access_error_flag_ff, 4'h0};
            `FCC_IDX_CMD: rd_mux = cmd_ff & `FCC_CMD_MASK;
            `FCC_IDX_TADDRH: rd_mux = {3'h0, buf_addr_ff[12:8]};
            `FCC_IDX_TADDRL: rd_mux = buf_addr_ff[7:0];
            `FCC_IDX_TDATAH: rd_mux = buf_data_ff[15:8];
            `FCC_IDX_TDATAL: rd_mux = buf_data_ff[7:0];
            `FCC_IDX_EVT: rd_mux = {4'h0, evt_ff};
            `FCC_IDX_MASK: rd_mux = {4'h0, mask_ff};
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // Read data held steady for the answering edge
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_ff <= 8'h00;
      end else if (AVS_READ_I && !ack_ff) begin
         rdata_ff <= rd_mux;
      end
   end

   // Clock divider register; any write marks it loaded
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         div_ld_ff <= 1'b0;
         pre8_ff <= 1'b0;
         divider_field_ff <= 6'h00;
      end else if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_CLKDIV)) begin
         div_ld_ff <= 1'b1;
         pre8_ff <= wd[`FCC_DIV_PRE8];
         divider_field_ff <= wd[5:0];
      end
   end

   // Configuration and protection registers
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         buffer_empty_irq_enable_ff <= 1'b0;
         complete_irq_enable_ff <= 1'b0;
         backdoor_key_access_ff <= 1'b0;
         prot_ff <= `FCC_PROT_RST;
      end else begin
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_CNFG)) begin
            buffer_empty_irq_enable_ff <= wd[`FCC_CNF_BUFFER_EMPTY_IRQ_ENABLE];
            complete_irq_enable_ff <= wd[`FCC_CNF_COMPLETE_IRQ_ENABLE];
            backdoor_key_access_ff <= wd[`FCC_CNF_BACKDOOR_KEY_ACCESS];
         end
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_PROT)) begin
            prot_ff <= wd;
         end
      end
   end

   // Sequence decode; a wrong step aborts and flags an access error
   always_comb begin
      arr_wr = AVS_WRITE_I && ack_ff && AVS_ADDRESS_I[`FCC_ARRAY_SEL] &&
               (AVS_BYTEENABLE_I[1:0] == 2'h3);
      arr_ok = command_buffer_empty_flag_ff && (seq_ff == SEQ_EMPTY) && !protection_violation_flag_ff && !access_error_flag_ff;
      cmd_wr = reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_CMD);
      launch_req = reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_STAT) && wd[`FCC_ST_COMMAND_BUFFER_EMPTY_FLAG];
      acc_set = (arr_wr && !arr_ok) ||
                (cmd_wr && ((seq_ff != SEQ_ADDR) || (wd != `FCC_CMD_PROGRAM))) ||
                (launch_req && (seq_ff == SEQ_ADDR)) ||
                (launch_req && (seq_ff == SEQ_CMD) && !div_ld_ff);
      pv_set = launch_req && (seq_ff == SEQ_CMD) && div_ld_ff &&
               is_protected(buf_addr_ff, prot_ff);
      launch = launch_req && (seq_ff == SEQ_CMD) && div_ld_ff &&
               !is_protected(buf_addr_ff, prot_ff);
   end

   // Command buffer and sequence state
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         seq_ff <= SEQ_EMPTY;
         buf_addr_ff <= 13'h0000;
         buf_data_ff <= 16'h0000;
         cmd_ff <= 8'h00;
      end else if (acc_set || pv_set || launch) begin
         seq_ff <= SEQ_EMPTY;
      end else if (arr_wr) begin
         seq_ff <= SEQ_ADDR;
         buf_addr_ff <= AVS_ADDRESS_I[14:2];
         buf_data_ff <= AVS_WRITEDATA_I[15:0];
      end else if (cmd_wr) begin
         seq_ff <= SEQ_CMD;
         cmd_ff <= wd;
      end else begin
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_TADDRH)) begin
            buf_addr_ff[12:8] <= wd[4:0];
         end
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_TADDRL)) begin
            buf_addr_ff[7:0] <= wd;
         end
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_TDATAH)) begin
            buf_data_ff[15:8] <= wd;
         end
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_TDATAL)) begin
            buf_data_ff[7:0] <= wd;
         end
      end
   end

   // Buffer empty drops at launch, rises when the engine takes it
   assign take = !command_buffer_empty_flag_ff && !busy_ff;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         command_buffer_empty_flag_ff <= 1'b1;
      end else if (launch) begin
         command_buffer_empty_flag_ff <= 1'b0;
      end else if (take) begin
         command_buffer_empty_flag_ff <= 1'b1;
      end
   end

   // Error flags: write one clears, a new error wins over the clear
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         protection_violation_flag_ff <= 1'b0;
         access_error_flag_ff <= 1'b0;
      end else begin
         if (pv_set) begin
            protection_violation_flag_ff <= 1'b1;
         end else if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_STAT) && wd[`FCC_ST_PROTECTION_VIOLATION_FLAG]) begin
            protection_violation_flag_ff <= 1'b0;
         end
         if (acc_set) begin
            access_error_flag_ff <= 1'b1;
         end else if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_STAT) && wd[`FCC_ST_ACCESS_ERROR_FLAG]) begin
            access_error_flag_ff <= 1'b0;
         end
      end
   end

   // Program engine, timed in divided flash clock periods
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         busy_ff <= 1'b0;
         ticks_ff <= 8'h00;
         strobe_ff <= 1'b0;
         pgm_addr_ff <= 13'h0000;
         pgm_data_ff <= 16'h0000;
      end else begin
         strobe_ff <= take;
         if (take) begin
            busy_ff <= 1'b1;
            ticks_ff <= `FCC_PGM_TICKS;
            pgm_addr_ff <= buf_addr_ff;
            pgm_data_ff <= buf_data_ff;
         end else if (busy_ff && div_if.tick) begin
            if (ticks_ff == 8'h01) begin
               busy_ff <= 1'b0;
            end
            ticks_ff <= ticks_ff - 8'h01;
         end
      end
   end

   assign PGM_ACTIVE_O = busy_ff;
   assign PGM_STROBE_O = strobe_ff;
   assign PGM_ADDR_O = pgm_addr_ff;
   assign PGM_DATA_O = pgm_data_ff;

   // Event sources, rising edges of the two flags plus errors
   assign evt_set[`FCC_EV_EMPTY] = command_buffer_empty_flag_ff && !command_buffer_empty_flag_d_ff;
   assign evt_set[`FCC_EV_DONE] = command_complete_flag && !command_complete_flag_d_ff;
   assign evt_set[`FCC_EV_PROTECTION_VIOLATION_FLAG] = pv_set;
   assign evt_set[`FCC_EV_ACCESS_ERROR_FLAG] = acc_set;

   // Sticky events, write one clears, set wins
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         evt_ff <= 4'h0;
         mask_ff <= 4'h0;
         command_buffer_empty_flag_d_ff <= 1'b1;
         command_complete_flag_d_ff <= 1'b1;
      end else begin
         command_buffer_empty_flag_d_ff <= command_buffer_empty_flag_ff;
         command_complete_flag_d_ff <= command_complete_flag;
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_EVT)) begin
            evt_ff <= (evt_ff & ~wd[3:0]) | evt_set;
         end else begin
            evt_ff <= evt_ff | evt_set;
         end
         if (reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_MASK)) begin
            mask_ff <= wd[3:0];
         end
      end
   end

   // Level interrupt; the flag enables also request while their flag is high
   assign IRQ_O = (|(evt_ff & mask_ff)) || (buffer_empty_irq_enable_ff && command_buffer_empty_flag_ff) || (complete_irq_enable_ff && command_complete_flag);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   div_flag_set_a: assert property (
      reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_CLKDIV) |=> div_ld_ff ##1 div_ld_ff)
      else $error("loaded flag not set after divider write");

   div_flag_cause_a: assert property (
      $rose(div_ld_ff) |-> $past(reg_wr(wr_go, reg_hit, reg_idx, `FCC_IDX_CLKDIV)))
      else $error("loaded flag rose without a divider write");

   no_div_err_a: assert property (
      (launch_req && (seq_ff == SEQ_CMD) && !div_ld_ff) |=> access_error_flag_ff && command_buffer_empty_flag_ff && !busy_ff)
      else $error("command ran without a loaded divider");

   capture_a: assert property (
      (arr_wr && arr_ok) |=> (seq_ff == SEQ_ADDR) && (buf_addr_ff == $past(AVS_ADDRESS_I[14:2]))
      && (buf_data_ff == $past(AVS_WRITEDATA_I[15:0])))
      else $error("array write not captured");

   launch_flag_a: assert property (
      launch |=> !command_buffer_empty_flag_ff ##1 ($past(busy_ff) || (busy_ff && command_buffer_empty_flag_ff)))
      else $error("launch did not pass command to engine");

   protect_block_a: assert property (
      pv_set |=> protection_violation_flag_ff && command_buffer_empty_flag_ff && (seq_ff == SEQ_EMPTY))
      else $error("protected target was not refused");

   done_flag_a: assert property (
      (busy_ff && div_if.tick && (ticks_ff == 8'h01) && command_buffer_empty_flag_ff && !launch) |=> command_complete_flag)
      else $error("complete flag missing after program");

   pipe_accept_a: assert property (
      (busy_ff && arr_wr && arr_ok && !(div_if.tick && (ticks_ff == 8'h01))) |=>
      (seq_ff == SEQ_ADDR) && busy_ff)
      else $error("pipelined sequence refused");

   engine_start_a: assert property (
      take |=> PGM_STROBE_O && busy_ff && (PGM_ADDR_O == $past(buf_addr_ff)))
      else $error("engine start wrong");

   tick_pace_a: assert property (
      $fell(busy_ff) |-> $past(div_if.tick) && ($past(ticks_ff) == 8'h01))
      else $error("program ended off a flash clock tick");

   bus_answer_a: assert property (
      (AVS_WRITE_I && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
      else $error("bus answer late");

   pgm_done_c: cover property (launch ##[1:1000] $fell(busy_ff));
   pipelined_c: cover property (busy_ff && launch);
   prot_hit_c: cover property (pv_set);
   no_div_c: cover property (acc_set && launch_req);
endmodule

/* tb/fcc_array_model.sv */
`timescale 1ns/100ps
// Array stand-in: keeps every programmed word, counts words programmed twice
module fcc_array_model (
   // Clock
   input wire logic clk_i,
   // Program port from the controller
   input wire logic strobe_i,
   input wire logic [12:0] addr_i,
   input wire logic [15:0] data_i,
   // Word seen by the array, and reprogram count
   output logic got_o,
   output logic [12:0] got_addr_o,
   output logic [15:0] got_data_o,
   output logic [7:0] reprog_o
);
   logic [15:0] mem_ff [0:8191];

   // Array starts fully erased
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem_ff[i] = 16'hffff;
      end
      got_o = 1'b0;
      got_addr_o = 13'h0000;
      got_data_o = 16'h0000;
      reprog_o = 8'h00;
   end

   // Only an erased word may be programmed; anything else is counted
   always @(posedge clk_i) begin
      got_o <= strobe_i;
      if (strobe_i) begin
         if (mem_ff[addr_i] !== 16'hffff) begin
            reprog_o <= reprog_o + 8'h01;
         end
         mem_ff[addr_i] <= data_i;
         got_addr_o <= addr_i;
         got_data_o <= data_i;
      end
   end
endmodule

/* tb/flash_command_controller_bench.sv */
`timescale 1ns/100ps
`include "fcc_defs.svh"
module flash_command_controller_bench;
   typedef struct {logic [7:0] e; logic [7:0] m;} fcc_exp_t;
   logic clk = 1'b0, rst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, irq, act, stb, wreq, got;
   logic [15:0] adr = 16'h0000, gdat;
   logic [31:0] wdat = 32'h0, rdat, last;
   logic [3:0] be = 4'h0;
   logic [12:0] paddr, gadr, a;
   logic [15:0] pdata, d;
   logic [7:0] reprog, r;
   int mismatches = 0, checked = 0, seed = 25039, cnt = 0, run = 0;
   fcc_exp_t rd_q[$];
   logic [28:0] pgm_q[$];
   int dur_q[$];
   fcc_exp_t e;

   fcc_ctrl uut (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s),
      .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wreq), .IRQ_O(irq), .PGM_ACTIVE_O(act), .PGM_STROBE_O(stb),
      .PGM_ADDR_O(paddr), .PGM_DATA_O(pdata));
   fcc_array_model arr (.clk_i(clk), .strobe_i(stb), .addr_i(paddr), .data_i(pdata),
      .got_o(got), .got_addr_o(gadr), .got_data_o(gdat), .reprog_o(reprog));

   // 25 MHz bus clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] x, input string w);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h want %h", $time, w, g, x);
      end
   endtask

   task automatic cmp_word(input logic [28:0] g, input logic [28:0] x);
      cmp_reg({3'h0, g}, {3'h0, x}, "programmed word");
   endtask

   task automatic cmp_time(input int n, input int per);
      checked++;
      if ((n + per - 1) / per != `FCC_PGM_TICKS) begin
         mismatches++;
         $display("MISMATCH %0t program ran %0d cycles at tick %0d", $time, n, per);
      end
   endtask

   // One Avalon access; held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [15:0] ad, input logic [31:0] dt,
                      input logic [3:0] b);
      int n;
      n = 0;
      adr <= ad;
      wdat <= dt;
      be <= b;
      if (w) wr_s <= 1'b1;
      else rd_s <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      last = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         tally_and_finish();
      end
      // Idle cycle so the next request never lands in the release step
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] i, input logic [7:0] v);
      bus(1'b1, {9'h000, i, 2'b00}, {24'h0, v}, 4'h1);
   endtask

   task automatic rd(input logic [4:0] i, input logic [7:0] x, input logic [7:0] m);
      rd_q.push_back('{x, m});
      bus(1'b0, {9'h000, i, 2'b00}, 32'h0, 4'h1);
   endtask

   // Poll a status bit until it shows the wanted level, bounded
   task automatic poll(input int bt, input logic v);
      int n;
      n = 0;
      do begin
         rd(`FCC_IDX_STAT, 8'h00, 8'h00);
         n++;
      end while (last[bt] !== v && n < 5000);
      if (n >= 5000) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   // Array word, command code, launch; a good launch notes word and tick period
   task automatic seq(input logic [12:0] wa, input logic [15:0] wd, input logic [7:0] c,
                      input int per);
      bus(1'b1, {1'b1, wa, 2'b00}, {16'h0, wd}, 4'hf);
      wr(`FCC_IDX_CMD, c);
      if (per > 0) begin
         pgm_q.push_back({wa, wd});
         dur_q.push_back(per);
      end
      wr(`FCC_IDX_STAT, 8'h80);
   endtask

   // Watcher: read data, programmed words, program run time
   always @(negedge clk) begin
      if (rd_s && wreq === 1'b0 && rd_q.size() > 0) begin
         e = rd_q.pop_front();
         if (e.m != 8'h00) cmp_reg(rdat & {24'h0, e.m}, {24'h0, e.e & e.m}, "read");
      end
      if (got === 1'b1) begin
         if (pgm_q.size() > 0) cmp_word({gadr, gdat}, pgm_q.pop_front());
         else cmp_reg(32'h1, 32'h0, "unexpected program");
      end
      if (run != 0 && (act !== 1'b1 || stb === 1'b1)) begin
         if (dur_q.size() > 0) cmp_time(cnt, dur_q.pop_front());
         run = 0;
      end
      if (stb === 1'b1) begin
         run = 1;
         cnt = 0;
      end
      if (run != 0) cnt++;
   end

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset values, reserved and unmapped places
      rd(`FCC_IDX_CLKDIV, 8'h00, 8'hff);
      rd(`FCC_IDX_SEC, `FCC_SEC_RST, 8'hff);
      rd(`FCC_IDX_PROT, `FCC_PROT_RST, 8'hff);
      rd(`FCC_IDX_STAT, 8'hc0, 8'hff);
      for (int k = 0; k < 7; k++) begin
         r = (k == 0) ? 8'h02 : (k == 1) ? 8'h07 : (k == 6) ? 8'h12 : 8'h0a + k[7:0];
         wr(r[4:0], 8'h5a);
         rd(r[4:0], 8'h00, 8'hff);
      end
      // Sequence with the divider never written is refused, event raises the line
      seq(13'h0010, 16'h1234, `FCC_CMD_PROGRAM, 0);
      rd(`FCC_IDX_STAT, 8'hd0, 8'hff);
      cmp_reg({31'h0, irq}, 32'h0, "irq masked");
      wr(`FCC_IDX_MASK, 8'h08);
      cmp_reg({31'h0, irq}, 32'h1, "irq raised");
      wr(`FCC_IDX_EVT, 8'h08);
      cmp_reg({31'h0, irq}, 32'h0, "irq cleared");
      wr(`FCC_IDX_MASK, 8'h00);
      // Flag enables raise the line while buffer empty and complete stand
      wr(`FCC_IDX_CNFG, 8'hc0);
      rd(`FCC_IDX_CNFG, 8'hc0, 8'hff);
      cmp_reg({31'h0, irq}, 32'h1, "irq flag enable");
      wr(`FCC_IDX_CNFG, 8'h00);
      cmp_reg({31'h0, irq}, 32'h0, "irq flag disable");
      wr(`FCC_IDX_STAT, 8'h10);
      rd(`FCC_IDX_STAT, 8'hc0, 8'hff);
      // Loaded flag sets on any write and ignores the written bit
      r = 8'($random(seed));
      wr(`FCC_IDX_CLKDIV, r);
      rd(`FCC_IDX_CLKDIV, 8'h80 | r, 8'hff);
      // Divide by 8 x 16: about 195 kHz, period plus bus period above 5 us
      wr(`FCC_IDX_CLKDIV, 8'h4f);
      // Program, then a pipelined second word while the first still runs
      a = 13'($random(seed));
      a[0] = 1'b0;
      d = 16'($random(seed));
      seq(a, d, `FCC_CMD_PROGRAM, 128);
      rd(`FCC_IDX_TADDRL, a[7:0], 8'hff);
      rd(`FCC_IDX_TADDRH, {3'h0, a[12:8]}, 8'h1f);
      rd(`FCC_IDX_TDATAH, d[15:8], 8'hff);
      rd(`FCC_IDX_TDATAL, d[7:0], 8'hff);
      poll(`FCC_ST_COMMAND_BUFFER_EMPTY_FLAG, 1'b1);
      seq(a + 13'h1, ~d, `FCC_CMD_PROGRAM, 128);
      rd(`FCC_IDX_STAT, 8'h00, 8'h40);
      poll(`FCC_ST_COMMAND_COMPLETE_FLAG, 1'b1);
      rd(`FCC_IDX_EVT, 8'h02, 8'h02);
      wr(`FCC_IDX_EVT, 8'h0f);
      // Slower flash clock (8 x 20, about 156 kHz) stretches the run in proportion
      wr(`FCC_IDX_CLKDIV, 8'h53);
      seq(a + 13'h5, 16'h00f0, `FCC_CMD_PROGRAM, 160);
      poll(`FCC_ST_COMMAND_COMPLETE_FLAG, 1'b1);
      // Wrong command code is an access error
      seq(a + 13'h9, 16'h0f00, 8'h40, 0);
      rd(`FCC_IDX_STAT, 8'h90, 8'h90);
      wr(`FCC_IDX_STAT, 8'h10);
      // Whole array protected: violation and no launch
      wr(`FCC_IDX_PROT, 8'h00);
      rd(`FCC_IDX_PROT, 8'h00, 8'hff);
      seq(a + 13'h9, 16'h0f00, `FCC_CMD_PROGRAM, 0);
      rd(`FCC_IDX_STAT, 8'ha0, 8'hb0);
      wr(`FCC_IDX_STAT, 8'h20);
      rd(`FCC_IDX_STAT, 8'hc0, 8'hff);
      wr(`FCC_IDX_PROT, `FCC_PROT_RST);
      repeat (20) @(posedge clk);
      cmp_reg({24'h0, reprog}, 32'h0, "word programmed twice");
      cmp_reg(pgm_q.size() + dur_q.size(), 32'h0, "programs missing");
      tally_and_finish();
   end
endmodule
